// ===== hdl/pwi_window_interrupt.sv
`timescale 1ns/1ps
module pwi_window_interrupt #(
	parameter int TICK_US = pwi_pkg::OSC_TICK_US
) (
	input  wire logic                  clock,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	input  wire pwi_pkg::pwi_reg_req_t reg_req,
	output logic [7:0]                 reg_rdata,
	input  wire logic                  init_done_lock,
	input  wire pwi_pkg::pwi_sample_t  sample,
	input  wire logic                  osc_tick,
	input  wire logic                  pin_active_low,
	output logic                       int_active,
	output logic                       int_pin_out,
	output logic                       int_pin_oe,
	output logic                       array_error
);
	import pwi_pkg::*;

	localparam logic [TIMER_WIDTH-1:0] LOAD_16  =
		TIMER_WIDTH'(STRETCH_16_MS * US_PER_MS / TICK_US + 1);
	localparam logic [TIMER_WIDTH-1:0] LOAD_64  =
		TIMER_WIDTH'(STRETCH_64_MS * US_PER_MS / TICK_US + 1);
	localparam logic [TIMER_WIDTH-1:0] LOAD_256 =
		TIMER_WIDTH'(STRETCH_256_MS * US_PER_MS / TICK_US + 1);

	pwi_config_t config_q;
	logic [15:0] upper_threshold;
	logic [15:0] lower_threshold;
	logic [7:0]  check_q;
	logic        cond_q;
	logic        timer_running;

	// register writes, all locked once initialization ends
	wire wr_open   = reg_req.wr_en && !init_done_lock;
	wire wr_config = wr_open && reg_req.addr == ADDR_INT_CONFIG;
	wire wr_up_l   = wr_open && reg_req.addr == ADDR_UPPER_L;
	wire wr_up_h   = wr_open && reg_req.addr == ADDR_UPPER_H;
	wire wr_lo_l   = wr_open && reg_req.addr == ADDR_LOWER_L;
	wire wr_lo_h   = wr_open && reg_req.addr == ADDR_LOWER_H;
	wire wr_any    = wr_config | wr_up_l | wr_up_h | wr_lo_l | wr_lo_h;

	wire pwi_config_t next_config = wr_config ? pwi_config_t'(reg_req.wdata) : config_q;
	wire [15:0] next_upper = {wr_up_h ? reg_req.wdata : upper_threshold[15:8],
		wr_up_l ? reg_req.wdata : upper_threshold[7:0]};
	wire [15:0] next_lower = {wr_lo_h ? reg_req.wdata : lower_threshold[15:8],
		wr_lo_l ? reg_req.wdata : lower_threshold[7:0]};

	// array check: signature kept at write time, compared against live contents
	wire [7:0] live_check = 8'(config_q) ^ upper_threshold[15:8] ^ upper_threshold[7:0]
		^ lower_threshold[15:8] ^ lower_threshold[7:0];
	wire [7:0] next_check = 8'(next_config) ^ next_upper[15:8] ^ next_upper[7:0]
		^ next_lower[15:8] ^ next_lower[7:0];
	assign array_error = (check_q != live_check);

	wire [7:0] rd_mux =
		(reg_req.addr == ADDR_INT_CONFIG) ? 8'(config_q) :
		(reg_req.addr == ADDR_UPPER_L)    ? upper_threshold[7:0] :
		(reg_req.addr == ADDR_UPPER_H)    ? upper_threshold[15:8] :
		(reg_req.addr == ADDR_LOWER_L)    ? lower_threshold[7:0] :
		(reg_req.addr == ADDR_LOWER_H)    ? lower_threshold[15:8] : READ_UNMAPPED;

	// window comparator
	wire upper_on   = (upper_threshold != THRESHOLD_RESET);
	wire lower_on   = (lower_threshold != THRESHOLD_RESET);
	wire above      = upper_on && (sample.pressure > upper_threshold);
	wire below      = lower_on && (sample.pressure < lower_threshold);
	wire outside    = above || below;
	wire any_on     = upper_on || lower_on;
	wire next_cond  = any_on && (config_q.window_sense ? !outside : outside);
	wire stretching = (config_q.stretch_select != STRETCH_NONE);

	wire [TIMER_WIDTH-1:0] load_value =
		(config_q.stretch_select == STRETCH_16) ? LOAD_16 :
		(config_q.stretch_select == STRETCH_64) ? LOAD_64 : LOAD_256;
	wire timer_load = sample.valid && next_cond && stretching;

	assign int_active  = stretching ? timer_running : cond_q;
	assign int_pin_out = !pin_active_low;
	assign int_pin_oe  = int_active;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			config_q        <= pwi_config_t'(CONFIG_RESET);
			upper_threshold <= THRESHOLD_RESET;
			lower_threshold <= THRESHOLD_RESET;
			check_q         <= CHECK_RESET;
		end else if (ce) begin
			config_q        <= next_config;
			upper_threshold <= next_upper;
			lower_threshold <= next_lower;
			if (wr_any) begin
				check_q <= next_check;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cond_q    <= 1'b0;
			reg_rdata <= READ_UNMAPPED;
		end else if (ce) begin
			if (sample.valid) begin
				cond_q <= next_cond;
			end
			if (reg_req.rd_en) begin
				reg_rdata <= rd_mux;
			end
		end
	end

	pwi_stretch_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.clock     (clock),
		.resetn    (resetn),
		.ce        (ce),
		.load      (timer_load),
		.load_value(load_value),
		.osc_tick  (osc_tick),
		.running   (timer_running)
	);

	sequence s_locked_config_write;
		ce && reg_req.wr_en && init_done_lock && reg_req.addr == ADDR_INT_CONFIG;
	endsequence

	sequence s_hit_16;
		ce && sample.valid && next_cond && config_q.stretch_select == STRETCH_16;
	endsequence

	a_lock_blocks_write: assert property (@(posedge clock) disable iff (!resetn)
		s_locked_config_write |=> $stable(config_q))
		else $error("locked interrupt_config changed");

	a_check_stays_clean: assert property (@(posedge clock) disable iff (!resetn)
		!array_error)
		else $error("register array check mismatch");

	a_stretch_load_16: assert property (@(posedge clock) disable iff (!resetn)
		s_hit_16 |=> timer_running && int_active)
		else $error("16 ms stretch did not start");

	a_direct_follow: assert property (@(posedge clock) disable iff (!resetn)
		ce && sample.valid && !stretching && !wr_config
		|=> int_active == $past(next_cond))
		else $error("direct output does not follow the latest sample");

	a_stretch_follow: assert property (@(posedge clock) disable iff (!resetn)
		stretching |-> int_active == timer_running)
		else $error("stretched output not driven by timer");

	a_inside_window: assert property (@(posedge clock) disable iff (!resetn)
		ce && sample.valid && config_q.window_sense && upper_on && lower_on
		&& sample.pressure >= lower_threshold && sample.pressure <= upper_threshold
		|=> cond_q)
		else $error("inside-window sample did not fire");

	a_both_zero_off: assert property (@(posedge clock) disable iff (!resetn)
		ce && sample.valid && !upper_on && !lower_on |=> !cond_q)
		else $error("interrupt fired with both thresholds zero");

	a_pin_sense: assert property (@(posedge clock) disable iff (!resetn)
		int_active |-> int_pin_oe && (int_pin_out == !pin_active_low))
		else $error("pin drive level wrong");

	// lock and array check
	a_threshold_locked: assert property (@(posedge clock) disable iff (!resetn)
		ce && reg_req.wr_en && init_done_lock
		|=> $stable(upper_threshold) && $stable(lower_threshold))
		else $error("locked threshold changed");

	a_config_in_check: assert property (@(posedge clock) disable iff (!resetn)
		ce && wr_config && reg_req.wdata != 8'(config_q) |=> check_q != $past(check_q))
		else $error("config write did not reach the array signature");

	// stretch timer load
	a_idle_no_load: assert property (@(posedge clock) disable iff (!resetn)
		ce && !timer_load && !timer_running |=> !timer_running)
		else $error("stretch timer started without a hit");

	a_hit_loads_timer: assert property (@(posedge clock) disable iff (!resetn)
		ce && timer_load |=> timer_running)
		else $error("hit did not load the stretch timer");

	// condition capture
	a_cond_holds: assert property (@(posedge clock) disable iff (!resetn)
		ce && !sample.valid |=> $stable(cond_q))
		else $error("condition changed without a sample");

	a_enable_freeze: assert property (@(posedge clock) disable iff (!resetn)
		!ce |=> $stable(config_q) && $stable(upper_threshold) && $stable(lower_threshold)
		&& $stable(cond_q) && $stable(reg_rdata) && $stable(timer_running))
		else $error("state moved while clock enable was low");

	a_upper_alone: assert property (@(posedge clock) disable iff (!resetn)
		ce && sample.valid && upper_on && !lower_on && !config_q.window_sense
		&& sample.pressure > upper_threshold |=> cond_q)
		else $error("upper threshold alone did not fire");

	a_lower_below: assert property (@(posedge clock) disable iff (!resetn)
		ce && sample.valid && lower_on && !config_q.window_sense
		&& sample.pressure < lower_threshold |=> cond_q)
		else $error("sample below lower threshold did not fire");

	a_sense_outside_off: assert property (@(posedge clock) disable iff (!resetn)
		ce && sample.valid && config_q.window_sense && upper_on
		&& sample.pressure > upper_threshold |=> !cond_q)
		else $error("outside sample fired with inside sense");

endmodule : pwi_window_interrupt

// ===== hdl/pwi_pkg.sv
package pwi_pkg;

	// register offsets
	localparam logic [7:0] ADDR_INT_CONFIG = 8'h45;
	localparam logic [7:0] ADDR_UPPER_L    = 8'h46;
	localparam logic [7:0] ADDR_UPPER_H    = 8'h47;
	localparam logic [7:0] ADDR_LOWER_L    = 8'h48;
	localparam logic [7:0] ADDR_LOWER_H    = 8'h49;

	// values after reset
	localparam logic [7:0]  CONFIG_RESET    = 8'h00;
	localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
	localparam logic [7:0]  CHECK_RESET     = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

	// field positions in interrupt_config
	localparam int STRETCH_LSB     = 4;
	localparam int WINDOW_SENSE_BIT = 3;

	// stretch select encodings
	localparam logic [1:0] STRETCH_NONE = 2'h0;
	localparam logic [1:0] STRETCH_16   = 2'h1;
	localparam logic [1:0] STRETCH_64   = 2'h2;
	localparam logic [1:0] STRETCH_256  = 2'h3;

	// nominal hold times in ms, and the oscillator tick period in us
	localparam int STRETCH_16_MS  = 16;
	localparam int STRETCH_64_MS  = 64;
	localparam int STRETCH_256_MS = 256;
	localparam int US_PER_MS      = 1000;
	localparam int OSC_TICK_US    = 16;
	localparam int TIMER_WIDTH    = 15;

	typedef struct packed {
		logic [1:0] reserved_hi;
		logic [1:0] stretch_select;
		logic       window_sense;
		logic [2:0] reserved_lo;
	} pwi_config_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] pressure;
	} pwi_sample_t;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pwi_reg_req_t;

endpackage : pwi_pkg

// ===== hdl/pwi_stretch_timer.sv
`timescale 1ns/1ps
module pwi_stretch_timer #(
	parameter int WIDTH = 15
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             ce,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             osc_tick,
	output logic                  running
);
	import pwi_pkg::*;

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	wire              counting = (count != '0);

	// a reload wins over a tick in the same cycle
	assign next_count = load ? load_value :
		(osc_tick && counting) ? count - 1'b1 : count;
	assign running = counting;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
		end else if (ce) begin
			count <= next_count;
		end
	end

	a_tick_decrement: assert property (@(posedge clock) disable iff (!resetn)
		ce && osc_tick && counting && !load |=> count == $past(count) - 1'b1)
		else $error("stretch timer did not step down on a tick");

	a_hold_no_event: assert property (@(posedge clock) disable iff (!resetn)
		ce && !osc_tick && !load |=> $stable(count))
		else $error("stretch timer moved without tick or reload");

endmodule : pwi_stretch_timer

// ===== bench/pwi_host_model.sv
`timescale 1ns/1ps
module pwi_host_model (
	input  wire logic pin_out,
	input  wire logic pin_oe,
	input  wire logic active_low,
	output logic      pin_level,
	output logic      irq_seen
);
	// a released pin settles to its pull: up when active low, down otherwise
	assign pin_level = pin_oe ? pin_out : active_low;
	assign irq_seen  = pin_level ^ active_low;
endmodule : pwi_host_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
	import pwi_pkg::*;
	logic         clock          = 1'b0;
	logic         resetn         = 1'b0;
	logic         ce             = 1'b1;
	logic         init_done_lock = 1'b0;
	logic         osc_tick       = 1'b0;
	logic         pin_active_low = 1'b0;
	pwi_reg_req_t reg_req        = '0;
	pwi_sample_t  sample         = '0;
	logic [7:0]   reg_rdata;
	logic [7:0]   rv;
	logic         int_active;
	logic         int_pin_out;
	logic         int_pin_oe;
	logic         array_error;
	logic         pin_level;
	logic         irq_seen;
	int           fails          = 0;
	int           tests_run      = 0;
	int           n;
	int           lo;

	initial forever #2.5 clock = ~clock;

	pwi_window_interrupt #(.TICK_US(1000)) i_pwi_window_interrupt (
		.clock(clock), .resetn(resetn), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.init_done_lock(init_done_lock), .sample(sample), .osc_tick(osc_tick),
		.pin_active_low(pin_active_low), .int_active(int_active), .int_pin_out(int_pin_out),
		.int_pin_oe(int_pin_oe), .array_error(array_error)
	);

	pwi_host_model i_pwi_host_model (
		.pin_out(int_pin_out), .pin_oe(int_pin_oe), .active_low(pin_active_low),
		.pin_level(pin_level), .irq_seen(irq_seen)
	);

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(negedge clock);
		reg_req.wr_en = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clock);
		reg_req.rd_en = 1'b0;
		d = reg_rdata;
	endtask : rd

	task automatic smp(input logic [15:0] p);
		@(negedge clock);
		sample = '{valid: 1'b1, pressure: p};
		@(negedge clock);
		sample.valid = 1'b0;
	endtask : smp

	task automatic tick();
		@(negedge clock);
		osc_tick = 1'b1;
		@(negedge clock);
		osc_tick = 1'b0;
	endtask : tick

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		final_report();
	end

	initial begin
		repeat (16) @(negedge clock);
		resetn = 1'b1;
		for (int a = 8'h44; a <= 8'h4A; a++) begin
			rd(8'(a), rv);
			`CHK(rv, 8'h00)
		end
		$display("test reset values done");
		smp(16'h1234);
		`CHK(int_active, 1'b0)
		wr(ADDR_UPPER_H, 8'h10);
		smp(16'h1001);
		`CHK(int_active, 1'b1)
		smp(16'h1000);
		`CHK(int_active, 1'b0)
		// window becomes 0020h..1000h
		wr(ADDR_LOWER_L, 8'h20);
		smp(16'h001F);
		`CHK(int_active, 1'b1)
		wr(ADDR_INT_CONFIG, 8'h08);
		smp(16'h0020);
		`CHK(int_active, 1'b1)
		`CHK(irq_seen, 1'b1)
		pin_active_low = 1'b1;
		#1 `CHK(pin_level, 1'b0)
		pin_active_low = 1'b0;
		smp(16'h1001);
		`CHK(int_active, 1'b0)
		`CHK(array_error, 1'b0)
		$display("test window compare done");
		// mode 1 reloads at the fifth tick, the others see a sample that must not reload
		for (int s = 1; s <= 3; s++) begin
			wr(ADDR_INT_CONFIG, 8'(s << 4));
			smp(16'h2000);
			`CHK(int_active, 1'b1)
			lo = (16 << (2 * (s - 1))) + ((s == 1) ? 5 : 0);
			n = 0;
			while (int_active === 1'b1 && n < 300) begin
				tick();
				n++;
				if (n == 5) smp((s == 1) ? 16'h2000 : 16'h0100);
			end
			`CHK((n >= lo) && (n <= lo + 1), 1'b1)
		end
		$display("test stretch done");
		ce = 1'b0;
		smp(16'h2000);
		wr(ADDR_UPPER_L, 8'h55);
		ce = 1'b1;
		`CHK(int_active, 1'b0)
		rd(ADDR_UPPER_L, rv);
		`CHK(rv, 8'h00)
		pin_active_low = 1'b1;
		#1 `CHK(pin_level, 1'b1)
		`CHK(irq_seen, 1'b0)
		pin_active_low = 1'b0;
		$display("test enable and release done");
		init_done_lock = 1'b1;
		wr(ADDR_INT_CONFIG, 8'hC8);
		rd(ADDR_INT_CONFIG, rv);
		`CHK(rv, 8'h30)
		`CHK(array_error, 1'b0)
		$display("test lock done");
		resetn = 1'b0;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		rd(ADDR_INT_CONFIG, rv);
		`CHK(rv, 8'h00)
		$display("test second reset done");
		final_report();
	end
endmodule : tb_top
